// ===== logic/mcuilt_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "mcuilt_cfg.svh"

// What this block does
// - Indirect accumulator move: one byte, two cycles
// - Immediate to indirect: two bytes, two cycles
// - Direct-to-direct and immediate-to-direct: three/three
// - Data pointer immediate load: three bytes, three cycles
// - Code memory read: one byte, four cycles
// - Extended data move: one byte, four cycles
// - Push and pop: two bytes, two cycles
// - Exchange register 1/1, direct 2/2
// - Nibble and indirect exchange: one byte, two cycles
// - Carry-bit moves and bit writes: two/two
// - Carry AND/OR with bit or inverse: two/two
// - Both returns: one byte, four cycles
// - Absolute call and jump: two bytes, three cycles
// - Short relative jump: two bytes, three cycles
// - Carry jumps: two bytes, three cycles
// - Accumulator zero jumps: two bytes, three cycles
// - Long call and jump: three bytes, four cycles
// - Bit jumps: three bytes, four cycles
// - Jump on set bit clears it: three/four
// - Compare and jump forms: three bytes, four cycles
// - Register decrement jump: two bytes, three cycles
// - Direct decrement jump: three bytes, four cycles
// - Most instructions take one or two cycles
// - Extended data uses internal 256-byte RAM only
module mcuilt_decoder (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Instruction issue
    input  wire logic        i_op_valid,
    input  wire logic [7:0]  i_opcode,
    input  wire logic [7:0]  i_byte1,
    input  wire logic [7:0]  i_byte2,
    input  wire logic [15:0] i_pc,
    output logic             o_op_ready,
    // Operands and conditions
    input  wire logic [7:0]  i_acc,
    input  wire logic [15:0] i_data_pointer_16,
    input  wire logic [7:0]  i_ptr_reg,
    input  wire logic [7:0]  i_mem_data,
    input  wire logic        i_carry,
    input  wire logic        i_bit_val,
    input  wire logic        i_cmp_ne,
    input  wire logic        i_dec_nonzero,
    input  wire logic [15:0] i_ret_addr,
    // Completion and results
    output logic             o_done,
    output logic [1:0]       o_len,
    output logic [3:0]       o_cycles,
    output logic             o_taken,
    output logic [15:0]      o_next_pc,
    output logic             o_bit_clear,
    output logic             o_carry_res,
    output logic [15:0]      o_code_addr,
    output logic [7:0]       o_xch_acc,
    output logic [7:0]       o_xch_mem,
    output logic [7:0]       o_xram_rdata
);

    mcuilt_pkg::mcuilt_state_s s_reg;   // Current state
    mcuilt_pkg::mcuilt_state_s s_next;  // Next state

    logic        acc_w;    // Instruction accepted this cycle
    logic        done_w;   // Last cycle of current instruction
    logic [5:0]  lc_w;     // Decoded length and cycles
    logic [15:0] seq_w;    // Address of following instruction
    logic [15:0] rel1_w;   // Relative target, displacement in byte 1
    logic [15:0] rel2_w;   // Relative target, displacement in byte 2
    logic [15:0] tgt_w;    // Resolved next address
    logic        tk_w;     // Branch decision
    logic        carry_w;  // Carry after bit operation
    logic        xwe_w;    // Extended RAM write
    logic        xre_w;    // Extended RAM read
    logic [7:0]  xaddr_w;  // Extended RAM address

    // Byte count and cycle count per opcode
    function automatic logic [5:0] dec_lc(input logic [7:0] op);
        logic [5:0] r;
        r = {`ILT_L1, `ILT_C1};
        casez (op)
            8'h00: r = {`ILT_L1, `ILT_C1};
            8'b????_0001: r = {`ILT_L2, `ILT_C3};
            8'h02, 8'h12: r = {`ILT_L3, `ILT_C4};
            8'h22, 8'h32: r = {`ILT_L1, `ILT_C4};
            8'h10, 8'h20, 8'h30: r = {`ILT_L3, `ILT_C4};
            8'h40, 8'h50: r = {`ILT_L2, `ILT_C3};
            8'h60, 8'h70: r = {`ILT_L2, `ILT_C3};
            8'h80: r = {`ILT_L2, `ILT_C3};
            8'h90: r = {`ILT_L3, `ILT_C3};
            8'h83, 8'h93: r = {`ILT_L1, `ILT_C4};
            8'hE0, 8'hE2, 8'hE3: r = {`ILT_L1, `ILT_C4};
            8'hF0, 8'hF2, 8'hF3: r = {`ILT_L1, `ILT_C4};
            8'hC0, 8'hD0: r = {`ILT_L2, `ILT_C2};
            8'h72, 8'h82, 8'hA0, 8'hB0: r = {`ILT_L2, `ILT_C2};
            8'h92, 8'hA2, 8'hB2: r = {`ILT_L2, `ILT_C2};
            8'hC2, 8'hD2: r = {`ILT_L2, `ILT_C2};
            // Logic ops with direct destination
            8'h42, 8'h52, 8'h62: r = {`ILT_L2, `ILT_C2};
            8'h43, 8'h53, 8'h63: r = {`ILT_L3, `ILT_C3};
            // Indirect jump and pointer increment
            8'h73: r = {`ILT_L1, `ILT_JMPI_C};
            8'hA3: r = {`ILT_L1, `ILT_C3};
            // Multiply, divide and decimal adjust
            8'h84, 8'hA4: r = {`ILT_L1, `ILT_C9};
            8'hD4: r = {`ILT_L1, `ILT_C2};
            // Single-byte accumulator ops and spare code, then compare and decrement jumps, moves and direct exchange
            8'h04, 8'h14, 8'hC4, 8'hE4: r = {`ILT_L1, `ILT_C1};
            8'hF4, 8'hA5: r = {`ILT_L1, `ILT_C1};
            8'hB4, 8'hB5: r = {`ILT_L3, `ILT_C4};
            8'b1011_011?, 8'b1011_1???: r = {`ILT_L3, `ILT_C4};
            8'hD5: r = {`ILT_L3, `ILT_C4};
            8'b1101_1???: r = {`ILT_L2, `ILT_C3};
            8'h75, 8'h85: r = {`ILT_L3, `ILT_C3};
            8'h76, 8'h77: r = {`ILT_L2, `ILT_C2};
            8'hC5: r = {`ILT_L2, `ILT_C2};
            // Register moves with direct or immediate operand
            8'b0111_1???, 8'b1000_1???: r = {`ILT_L2, `ILT_C2};
            8'b1010_1???: r = {`ILT_L2, `ILT_C2};
            8'h86, 8'h87, 8'hA6, 8'hA7: r = {`ILT_L2, `ILT_C2};
            8'b1100_011?, 8'b1101_011?: r = {`ILT_L1, `ILT_C2};
            8'b????_011?: r = {`ILT_L1, `ILT_C2};
            8'b????_1???: r = {`ILT_L1, `ILT_C1};
            8'b????_010?: r = {`ILT_L2, `ILT_C2};
            default: r = {`ILT_L1, `ILT_C1};
        endcase
        return r;
    endfunction

    assign lc_w   = dec_lc(i_opcode);
    assign done_w = (s_reg.st == mcuilt_pkg::ST_EXEC) && (s_reg.cnt == 4'h0);
    // Next instruction may issue in the last cycle of the current one
    assign o_op_ready = (s_reg.st == mcuilt_pkg::ST_IDLE) || done_w;
    assign acc_w  = i_op_valid && o_op_ready;

    // Fall-through and relative targets
    assign seq_w  = i_pc + {14'h0, lc_w[5:4]};
    assign rel1_w = seq_w + {{8{i_byte1[7]}}, i_byte1};
    assign rel2_w = seq_w + {{8{i_byte2[7]}}, i_byte2};

    // Branch decision and target selection
    always_comb begin
        tk_w  = 1'b0;
        tgt_w = seq_w;
        casez (i_opcode)
            8'b????_0001: begin
                tk_w  = 1'b1;
                tgt_w = {seq_w[15:11], i_opcode[7:5], i_byte1};
            end
            8'h02, 8'h12: begin
                tk_w  = 1'b1;
                tgt_w = {i_byte1, i_byte2};
            end
            8'h22, 8'h32: begin
                tk_w  = 1'b1;
                tgt_w = i_ret_addr;
            end
            8'h73: begin
                tk_w  = 1'b1;
                tgt_w = i_data_pointer_16 + {8'h00, i_acc};
            end
            8'h80: begin
                tk_w  = 1'b1;
                tgt_w = rel1_w;
            end
            8'h40, 8'h50: begin
                tk_w  = i_carry ^ i_opcode[4];
                tgt_w = rel1_w;
            end
            8'h60, 8'h70: begin
                tk_w  = (i_acc == 8'h00) ^ i_opcode[4];
                tgt_w = rel1_w;
            end
            8'b1101_1???: begin
                tk_w  = i_dec_nonzero;
                tgt_w = rel1_w;
            end
            8'h10, 8'h20: begin
                tk_w  = i_bit_val;
                tgt_w = rel2_w;
            end
            8'h30: begin
                tk_w  = !i_bit_val;
                tgt_w = rel2_w;
            end
            8'hB4, 8'hB5, 8'b1011_011?, 8'b1011_1???: begin
                tk_w  = i_cmp_ne;
                tgt_w = rel2_w;
            end
            8'hD5: begin
                tk_w  = i_dec_nonzero;
                tgt_w = rel2_w;
            end
            default: tk_w = 1'b0; // Not a control transfer
        endcase
        // Not taken falls through by the byte count
        if (!tk_w) begin
            tgt_w = seq_w;
        end
    end

    // Carry result of boolean instructions
    always_comb begin
        case (i_opcode)
            8'h82: carry_w = i_carry & i_bit_val;
            8'hB0: carry_w = i_carry & ~i_bit_val;
            8'h72: carry_w = i_carry | i_bit_val;
            8'hA0: carry_w = i_carry | ~i_bit_val;
            8'hA2: carry_w = i_bit_val;
            8'hC3: carry_w = 1'b0;
            8'hD3: carry_w = 1'b1;
            8'hB3: carry_w = ~i_carry;
            default: carry_w = i_carry;
        endcase
    end

    // Extended RAM access, started when the instruction issues
    assign xwe_w   = acc_w && (i_opcode inside {8'hF0, 8'hF2, 8'hF3});
    assign xre_w   = acc_w && (i_opcode inside {8'hE0, 8'hE2, 8'hE3});
    // Only the low pointer byte matters, no external bus exists
    assign xaddr_w = i_opcode[1] ? i_ptr_reg : i_data_pointer_16[7:0];

    // Sequencer and result capture
    always_comb begin
        s_next = s_reg;
        if (done_w) begin
            s_next.st = mcuilt_pkg::ST_IDLE;
        end else if (s_reg.st == mcuilt_pkg::ST_EXEC) begin
            s_next.cnt = s_reg.cnt - 4'h1;
        end
        if (acc_w) begin
            s_next.st      = mcuilt_pkg::ST_EXEC;
            s_next.cnt     = lc_w[3:0] - 4'h1;
            s_next.len     = lc_w[5:4];
            s_next.cyc     = lc_w[3:0];
            s_next.next_pc = tgt_w;
            s_next.taken   = tk_w;
            s_next.jump_bit_set_clear     = (i_opcode == 8'h10) && i_bit_val;
            s_next.carry   = carry_w;
            // Code read base is data pointer or following address
            if (i_opcode == 8'h83) begin
                s_next.code_addr = seq_w + {8'h00, i_acc};
            end else begin
                s_next.code_addr = i_data_pointer_16 + {8'h00, i_acc};
            end
            // Nibble exchange swaps the low halves only
            if (i_opcode inside {8'hD6, 8'hD7}) begin
                s_next.xch_acc = {i_acc[7:4], i_mem_data[3:0]};
                s_next.xch_mem = {i_mem_data[7:4], i_acc[3:0]};
            end else begin
                s_next.xch_acc = i_mem_data;
                s_next.xch_mem = i_acc;
            end
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Extended RAM
    mcuilt_xram #(.AW(`ILT_XRAM_AW)) u_xram (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_we    (xwe_w),
        .i_re    (xre_w),
        .i_addr  (xaddr_w),
        .i_wdata (i_acc),
        .o_rdata (o_xram_rdata)
    );

    // Outputs
    assign o_done      = done_w;
    assign o_len       = s_reg.len;
    assign o_cycles    = s_reg.cyc;
    assign o_taken     = s_reg.taken;
    assign o_next_pc   = s_reg.next_pc;
    assign o_bit_clear = done_w && s_reg.jump_bit_set_clear;
    assign o_carry_res = s_reg.carry;
    assign o_code_addr = s_reg.code_addr;
    assign o_xch_acc   = s_reg.xch_acc;
    assign o_xch_mem   = s_reg.xch_mem;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    AST_IND_MOVE: assert property (
        acc_w && i_opcode inside {8'hE6, 8'hE7, 8'hF6, 8'hF7}
        |=> o_len == `ILT_L1 && !o_done ##1 o_done)
        else $error("indirect move length or timing wrong");
    AST_IND_IMM: assert property (
        acc_w && i_opcode == 8'h76 |=> o_len == `ILT_L2 && o_cycles == `ILT_C2)
        else $error("immediate to indirect wrong");
    AST_DIR_DIR: assert property (
        acc_w && i_opcode inside {8'h75, 8'h85}
        |=> o_len == `ILT_L3 && !o_done[*2] ##1 o_done)
        else $error("direct move wrong");
    AST_DATA_POINTER_16_LOAD: assert property (
        acc_w && i_opcode == 8'h90 |=> o_len == `ILT_L3 && o_cycles == `ILT_C3)
        else $error("pointer load wrong");
    AST_CODE_READ: assert property (
        acc_w && i_opcode == 8'h93
        |=> o_code_addr == $past(i_data_pointer_16) + {8'h00, $past(i_acc)} && o_len == `ILT_L1)
        else $error("code read address wrong");
    AST_XDATA: assert property (
        acc_w && i_opcode inside {8'hE0, 8'hE2, 8'hF0, 8'hF3}
        |=> o_len == `ILT_L1 && !o_done[*3] ##1 o_done)
        else $error("extended move timing wrong");
    AST_STACK: assert property (
        acc_w && i_opcode inside {8'hC0, 8'hD0}
        |=> o_len == `ILT_L2 && !o_done ##1 o_done)
        else $error("stack op wrong");
    AST_XCH: assert property (
        acc_w && i_opcode[7:3] == 5'h19 |=> o_done && o_len == `ILT_L1)
        else $error("register exchange wrong");
    AST_LOW_NIBBLE_EXCHANGE: assert property (
        acc_w && i_opcode == 8'hD6
        |=> o_xch_acc == {$past(i_acc[7:4]), $past(i_mem_data[3:0])})
        else $error("nibble exchange wrong");
    AST_BIT_INV: assert property (
        acc_w && i_opcode == 8'hB0
        |=> o_carry_res == ($past(i_carry) & ~$past(i_bit_val)) && o_cycles == `ILT_C2)
        else $error("inverse bit and wrong");
    AST_RET: assert property (
        acc_w && i_opcode inside {8'h22, 8'h32}
        |=> ##3 o_done && o_next_pc == $past(i_ret_addr, 4))
        else $error("return wrong");
    AST_ABS: assert property (
        acc_w && i_opcode[4:0] == 5'h01
        |=> o_next_pc[10:0] == {$past(i_opcode[7:5]), $past(i_byte1)} ##2 o_done)
        else $error("absolute target wrong");
    AST_COND_REL: assert property (
        acc_w && i_opcode == 8'h40 |=> o_taken == $past(i_carry) ##2 o_done)
        else $error("carry jump wrong");
    AST_LONG: assert property (
        acc_w && i_opcode == 8'h02 |=> o_next_pc == {$past(i_byte1), $past(i_byte2)})
        else $error("long jump target wrong");
    AST_BIT_JUMP: assert property (
        acc_w && i_opcode inside {8'h20, 8'h30, 8'hB4, 8'hD5}
        |=> o_len == `ILT_L3 && !o_done[*3] ##1 o_done)
        else $error("three byte jump wrong");
    AST_JBC_CLR: assert property (
        acc_w && i_opcode == 8'h10 && i_bit_val |=> ##3 o_bit_clear && o_taken)
        else $error("bit not cleared");
    AST_NOP: assert property (
        acc_w && i_opcode == 8'h00 |=> o_done && o_next_pc == $past(i_pc) + 16'h0001)
        else $error("no-operation wrong");

    COV_BACK2BACK: cover property (o_done && acc_w);
    COV_JBC: cover property (o_bit_clear);
    COV_XRAM_RW: cover property (xwe_w ##[1:8] xre_w);

endmodule

`default_nettype wire

// ===== logic/mcuilt_cfg.svh
`ifndef MCUILT_CFG_SVH
`define MCUILT_CFG_SVH

// Instruction lengths in code bytes
`define ILT_L1 2'h1
`define ILT_L2 2'h2
`define ILT_L3 2'h3

// Instruction durations in core clock cycles
`define ILT_C1 4'h1
`define ILT_C2 4'h2
`define ILT_C3 4'h3
`define ILT_C4 4'h4
`define ILT_C9 4'h9

// Duration given to the indirect jump through the data pointer
`define ILT_JMPI_C 4'h3

// Program counter width
`define ILT_PC_W 16

// Extended RAM address width, 256 bytes
`define ILT_XRAM_AW 8

`endif

// ===== logic/mcuilt_pkg.sv
`include "mcuilt_cfg.svh"

package mcuilt_pkg;

    // Sequencer states
    typedef enum logic {
        ST_IDLE,
        ST_EXEC
    } mcuilt_st_e;

    // Whole state of the decoder
    typedef struct packed {
        mcuilt_st_e              st;        // Sequencer state
        logic [3:0]              cnt;       // Cycles left minus one
        logic [1:0]              len;       // Byte count of instruction
        logic [3:0]              cyc;       // Cycle count of instruction
        logic [`ILT_PC_W-1:0]    next_pc;   // Resolved next fetch address
        logic                    taken;     // Branch taken
        logic                    jump_bit_set_clear;       // Bit to be cleared at end
        logic                    carry;     // Carry after bit operation
        logic [`ILT_PC_W-1:0]    code_addr; // Code read address
        logic [7:0]              xch_acc;   // Accumulator after exchange
        logic [7:0]              xch_mem;   // Memory after exchange
    } mcuilt_state_s;

    // State of the extended RAM port
    typedef struct packed {
        logic [7:0]              rdata;     // Registered read data
    } mcuilt_xram_s;

endpackage

// ===== logic/mcuilt_xram.sv
`timescale 1ns/100ps
`default_nettype none
`include "mcuilt_cfg.svh"

// Internal extended RAM, one access per cycle, registered read data
module mcuilt_xram #(
    parameter int AW = `ILT_XRAM_AW
) (
    // Clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    // Access port
    input  wire logic          i_we,
    input  wire logic          i_re,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [7:0]    i_wdata,
    // Read data
    output logic      [7:0]    o_rdata
);

    mcuilt_pkg::mcuilt_xram_s s_reg;      // Port state
    mcuilt_pkg::mcuilt_xram_s s_next;     // Next port state
    logic [7:0]               mem [2**AW]; // Storage array

    // Read data follows the addressed byte on a read
    always_comb begin
        s_next = s_reg;
        if (i_re) begin
            s_next.rdata = mem[i_addr];
        end
    end

    // Storage write, no reset on the array
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
    end

    // Port state register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_rdata = s_reg.rdata;

endmodule

`default_nettype wire

// ===== verif/test_mcuilt_decoder.sv
`timescale 1ns/100ps
`default_nettype none

// Bench for the instruction length and timing decoder
module test_mcuilt_decoder;

    // One table row: opcode with its byte count and cycle count
    typedef struct packed {
        logic [7:0] op;
        logic [1:0] len;
        logic [3:0] cyc;
    } mcuilt_tb_row_s;

    localparam int NR = 48;

    logic        i_clk, i_rst, i_op_valid, i_carry, i_bit_val, i_cmp_ne, i_dec_nonzero;
    logic [7:0]  i_opcode, i_byte1, i_byte2, i_acc, i_ptr_reg, i_mem_data;
    logic [15:0] i_pc, i_data_pointer_16, i_ret_addr;
    logic        o_op_ready, o_done, o_taken, o_bit_clear, o_carry_res;
    logic [1:0]  o_len;
    logic [3:0]  o_cycles;
    logic [15:0] o_next_pc, o_code_addr;
    logic [7:0]  o_xch_acc, o_xch_mem, o_xram_rdata;
    int          n_errors;
    int          num_checks;
    int          k;

    // Ordinary cases, grouped by instruction family
    mcuilt_tb_row_s rows [NR] = '{
        '{8'hE6, 2'h1, 4'h2}, '{8'hF6, 2'h1, 4'h2},
        '{8'h76, 2'h2, 4'h2},
        '{8'h85, 2'h3, 4'h3}, '{8'h75, 2'h3, 4'h3},
        '{8'h90, 2'h3, 4'h3},
        '{8'h93, 2'h1, 4'h4}, '{8'h83, 2'h1, 4'h4},
        '{8'hE2, 2'h1, 4'h4}, '{8'hE0, 2'h1, 4'h4}, '{8'hF2, 2'h1, 4'h4},
        '{8'hF0, 2'h1, 4'h4},
        '{8'hC0, 2'h2, 4'h2}, '{8'hD0, 2'h2, 4'h2},
        '{8'hC8, 2'h1, 4'h1}, '{8'hC5, 2'h2, 4'h2},
        '{8'hD6, 2'h1, 4'h2}, '{8'hC6, 2'h1, 4'h2},
        '{8'h92, 2'h2, 4'h2}, '{8'hA2, 2'h2, 4'h2}, '{8'hC2, 2'h2, 4'h2},
        '{8'hD2, 2'h2, 4'h2}, '{8'hB2, 2'h2, 4'h2},
        '{8'h82, 2'h2, 4'h2}, '{8'hB0, 2'h2, 4'h2}, '{8'h72, 2'h2, 4'h2},
        '{8'hA0, 2'h2, 4'h2},
        '{8'h22, 2'h1, 4'h4}, '{8'h32, 2'h1, 4'h4},
        '{8'h11, 2'h2, 4'h3}, '{8'h01, 2'h2, 4'h3},
        '{8'h80, 2'h2, 4'h3},
        '{8'h40, 2'h2, 4'h3}, '{8'h50, 2'h2, 4'h3},
        '{8'h60, 2'h2, 4'h3}, '{8'h70, 2'h2, 4'h3},
        '{8'h02, 2'h3, 4'h4}, '{8'h12, 2'h3, 4'h4},
        '{8'h20, 2'h3, 4'h4}, '{8'h30, 2'h3, 4'h4},
        '{8'h10, 2'h3, 4'h4},
        '{8'hB5, 2'h3, 4'h4}, '{8'hB4, 2'h3, 4'h4}, '{8'hB8, 2'h3, 4'h4},
        '{8'hB6, 2'h3, 4'h4},
        '{8'hD8, 2'h2, 4'h3},
        '{8'hD5, 2'h3, 4'h4},
        '{8'h00, 2'h1, 4'h1}
    };

    // Device under test
    mcuilt_decoder uut (
        .i_clk(i_clk), .i_rst(i_rst), .i_op_valid(i_op_valid), .i_opcode(i_opcode),
        .i_byte1(i_byte1), .i_byte2(i_byte2), .i_pc(i_pc), .o_op_ready(o_op_ready),
        .i_acc(i_acc), .i_data_pointer_16(i_data_pointer_16), .i_ptr_reg(i_ptr_reg), .i_mem_data(i_mem_data),
        .i_carry(i_carry), .i_bit_val(i_bit_val), .i_cmp_ne(i_cmp_ne),
        .i_dec_nonzero(i_dec_nonzero), .i_ret_addr(i_ret_addr), .o_done(o_done),
        .o_len(o_len), .o_cycles(o_cycles), .o_taken(o_taken), .o_next_pc(o_next_pc),
        .o_bit_clear(o_bit_clear), .o_carry_res(o_carry_res), .o_code_addr(o_code_addr),
        .o_xch_acc(o_xch_acc), .o_xch_mem(o_xch_mem), .o_xram_rdata(o_xram_rdata)
    );

    // Core clock, 8 ns period
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // Value compare, zero-extended so unknowns still mismatch
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t value got %h exp %h", $time, got, exp);
        end
    endtask

    // Cycle count compare
    task automatic chk_n(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            n_errors++;
            $display("[ERR] %0t cycle count got %0d exp %0d", $time, got, exp);
        end
    endtask

    // Issue at a falling edge, return at the falling edge of the done cycle (one-cycle ops: one edge later)
    task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
                       output int cnt);
        i_op_valid = 1'b1;
        i_opcode   = op;
        i_byte1    = b1;
        i_byte2    = b2;
        @(negedge i_clk);
        i_op_valid = 1'b0;
        cnt = 1;
        while (o_done !== 1'b1 && cnt < 12) begin
            @(negedge i_clk);
            cnt++;
        end
        // Valid just fell in this step, so the next issue waits one edge
        if (cnt == 1) begin
            @(negedge i_clk);
        end
    endtask

    // Verdict and end of run
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #(8 * 4000);
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end

    // Main sequence
    initial begin
        n_errors = 0; num_checks = 0;
        i_rst = 1'b1; i_op_valid = 1'b0; i_opcode = 8'h00; i_byte1 = 8'h00;
        i_byte2 = 8'h00; i_pc = 16'h1000; i_acc = 8'h5A; i_data_pointer_16 = 16'h0000;
        i_ptr_reg = 8'h00; i_mem_data = 8'h00; i_carry = 1'b0; i_bit_val = 1'b0;
        i_cmp_ne = 1'b0; i_dec_nonzero = 1'b0; i_ret_addr = 16'h0000;
        repeat (4) @(negedge i_clk);
        // Idle values while reset is held
        chk(o_op_ready, 1'b1);
        chk(o_done, 1'b0);
        chk({o_len, o_cycles}, 6'h00);
        chk(o_next_pc, 16'h0000);
        i_rst = 1'b0;
        // Table walk, each row issued in the done cycle of the last (one-cycle rows: one later)
        for (int r = 0; r < NR; r++) begin
            run(rows[r].op, 8'h00, 8'h00, k);
            chk(o_len, rows[r].len);
            chk(o_cycles, rows[r].cyc);
            chk_n(k, int'(rows[r].cyc));
        end
        // Long jump; a request held while busy is ignored, then taken back-to-back
        i_op_valid = 1'b1; i_opcode = 8'h02; i_byte1 = 8'h12; i_byte2 = 8'h34;
        @(negedge i_clk);
        i_opcode = 8'h00;
        chk({o_len, o_cycles}, {2'h3, 4'h4});
        chk({o_taken, o_next_pc}, 17'h11234);
        chk(o_op_ready, 1'b0);
        repeat (2) @(negedge i_clk);
        chk({o_done, o_op_ready}, 2'h0);
        @(negedge i_clk);
        chk({o_done, o_op_ready}, 2'h3);
        // Valid stays up; the next issue follows in this done cycle
        @(negedge i_clk);
        chk({o_done, o_len, o_cycles}, {1'b1, 2'h1, 4'h1});
        chk({o_taken, o_next_pc}, 17'h01001);
        // Carry jump not taken, then taken backwards
        run(8'h40, 8'hFE, 8'h00, k);
        chk({o_taken, o_next_pc}, 17'h01002);
        i_carry = 1'b1;
        run(8'h40, 8'hFE, 8'h00, k);
        chk({o_taken, o_next_pc}, 17'h11000);
        // Bit jump and the set-and-clear form with the bit high
        i_pc = 16'h2000; i_bit_val = 1'b1;
        run(8'h20, 8'h07, 8'h10, k);
        chk({o_taken, o_next_pc, o_bit_clear}, 18'h24026);
        run(8'h10, 8'h07, 8'hF0, k);
        chk({o_taken, o_next_pc, o_bit_clear}, 18'h23FE7);
        // Nibble exchange keeps the upper halves in place
        i_acc = 8'hA5; i_mem_data = 8'h3C;
        run(8'hD6, 8'h00, 8'h00, k);
        chk({o_xch_acc, o_xch_mem}, 16'hAC35);
        run(8'hC6, 8'h00, 8'h00, k);
        chk({o_xch_acc, o_xch_mem}, 16'h3CA5);
        // Carry combined with an inverted bit
        run(8'hB0, 8'h07, 8'h00, k);
        chk(o_carry_res, 1'b0);
        i_carry = 1'b0; i_bit_val = 1'b0;
        run(8'hA0, 8'h07, 8'h00, k);
        chk(o_carry_res, 1'b1);
        // Extended RAM write via pointer, read back through a working register
        i_data_pointer_16 = 16'h0155; i_acc = 8'h77;
        run(8'hF0, 8'h00, 8'h00, k);
        i_ptr_reg = 8'h55; i_acc = 8'h00;
        run(8'hE2, 8'h00, 8'h00, k);
        chk(o_xram_rdata, 8'h77);
        // Code reads relative to the pointer and to the following address
        i_data_pointer_16 = 16'h8000; i_acc = 8'h02;
        run(8'h93, 8'h00, 8'h00, k);
        chk(o_code_addr, 16'h8002);
        run(8'h83, 8'h00, 8'h00, k);
        chk(o_code_addr, 16'h2003);
        // Conditional jumps taken on the core's compare, decrement and accumulator-zero results
        i_cmp_ne = 1'b1; i_dec_nonzero = 1'b1; i_ret_addr = 16'h4321;
        run(8'hB4, 8'h00, 8'h05, k);
        chk({o_taken, o_next_pc}, 17'h12008);
        run(8'hD8, 8'hFC, 8'h00, k);
        chk({o_taken, o_next_pc}, 17'h11FFE);
        run(8'hD5, 8'h00, 8'h01, k);
        chk({o_taken, o_next_pc}, 17'h12004);
        run(8'h70, 8'h02, 8'h00, k);
        chk({o_taken, o_next_pc}, 17'h12004);
        // Return, short and absolute targets
        run(8'h22, 8'h00, 8'h00, k);
        chk({o_taken, o_next_pc}, 17'h14321);
        run(8'h80, 8'h10, 8'h00, k);
        chk({o_taken, o_next_pc}, 17'h12012);
        run(8'hE1, 8'h34, 8'h00, k);
        chk({o_taken, o_next_pc}, 17'h12734);
        // Reset in mid-instruction drops back to idle
        i_op_valid = 1'b1; i_opcode = 8'h02;
        @(negedge i_clk);
        i_op_valid = 1'b0; i_rst = 1'b1;
        @(negedge i_clk);
        chk({o_done, o_op_ready, o_len, o_cycles}, 8'h40);
        // First issue right after release is taken
        i_rst = 1'b0;
        run(8'h00, 8'h00, 8'h00, k);
        chk_n(k, 1);
        chk({o_taken, o_next_pc}, 17'h02001);
        conclude();
    end

endmodule

`default_nettype wire
